/* File: core/led_display_pkg.sv */
package led_display_pkg;

    // ----------------------------------------------------------------
    // Display geometry and LED positions
    // ----------------------------------------------------------------
    localparam int LED_COUNT       = 16;
    localparam int LED_IDENT0      = 0;
    localparam int LED_IDENT1      = 1;
    localparam int LED_IDENT2      = 2;
    localparam int LED_CLK_PRESENT = 8;
    localparam int LED_PRND_EN     = 10;
    localparam int LED_CORR_SEL    = 11;
    localparam int LED_XFER_REQ    = 12;
    localparam int LED_XFER_NEXT   = 13;
    localparam int LED_EVENT_STB   = 14;
    localparam int LED_CFG_STB     = 15;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ            = 25_000_000;
    localparam int unsigned ADDR_SHOW_TIME_MS = 3000;
    localparam int unsigned ADDR_SHOW_CYCLES  = ADDR_SHOW_TIME_MS * (CLK_HZ / 1000);

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_FRAME  = 12'h008;
    localparam logic [11:0] OFS_ADDR   = 12'h00c;

    localparam int          CTRL_EN_BIT      = 0;
    localparam int          CTRL_FORCE_BIT   = 1;
    localparam int          CTRL_RESTART_BIT = 2;
    localparam logic [1:0]  CTRL_RESET       = 2'h1;
    localparam int          STATUS_INTRO_BIT = 0;
    localparam int          STATUS_CNT_LSB   = 16;

    // ----------------------------------------------------------------
    // Bus encodings
    // ----------------------------------------------------------------
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'h0;

endpackage

/* File: core/frame_rx.sv */
`timescale 1ns/10ps
module frame_rx
    import led_display_pkg::*;
#(
    parameter int W = LED_COUNT
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         data_s,
    input  wire logic         sync_s,
    output logic [W-1:0]      frame_reg,
    output logic              frame_stb_reg
);

    logic [W-2:0] shift_reg;
    logic [W-2:0] shift_next;
    logic [W-1:0] frame_next;
    logic         frame_stb_next;

    // ----------------------------------------------------------------
    // Shifter and frame latch
    // ----------------------------------------------------------------
    always_comb begin
        // RL2: sample every edge
        shift_next     = {shift_reg[W-3:0], data_s};
        frame_next     = frame_reg;
        frame_stb_next = 1'b0;
        // RL4: latch on sync
        if (sync_s) begin
            // RL9: sync bit is bit 0
            frame_next     = {shift_reg, data_s};
            frame_stb_next = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg     <= '0;
            frame_reg     <= '0;
            frame_stb_reg <= 1'b0;
        end else begin
            shift_reg     <= shift_next;
            frame_reg     <= frame_next;
            frame_stb_reg <= frame_stb_next;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_frame_lsbs: assert property (@(posedge hclk) disable iff (!hresetn) // RL9
        sync_s |=> (frame_reg[0] == $past(data_s)) && (frame_reg[1] == $past(data_s, 2)))
        else $error("latched frame low bits differ from sampled data");

    chk_frame_msb: assert property (@(posedge hclk) disable iff (!hresetn) // RL2
        sync_s |=> frame_reg[W-1] == $past(data_s, W))
        else $error("latched frame top bit differs from sampled data");

    chk_frame_hold: assert property (@(posedge hclk) disable iff (!hresetn) // RL4
        !sync_s |=> $stable(frame_reg) && !frame_stb_reg)
        else $error("frame changed without sync");

endmodule

/* File: core/led_display.sv */
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
// Operation
// RL1: Frames come on two wires, data and sync, clocked by the board clock.
// RL2: Serial data is sampled on every rising board clock edge.
// RL3: Sender raises sync for one clock, together with the last data bit.
// RL4: Sync seen high loads the preceding bits into the display registers.
// RL5: A sender on the board clock serialises with a plain shift register.
// RL6: Sixteen front-edge LEDs show status gathered from the other devices.
// RL7: After initialisation the board address is shown for several seconds.
// RL8: LEDs show ident bits, clock, pseudo-random enable, select, transfer and strobe flags.
// RL9: Fixed frame; each LED is a fixed bit counted back from sync.
module led_display
    import led_display_pkg::*;
#(
    parameter int unsigned SHOW_CYCLES = ADDR_SHOW_CYCLES
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic                 status_data_in,
    input  wire logic                 status_sync_in,
    input  wire logic [LED_COUNT-1:0] board_addr_in,
    output logic [LED_COUNT-1:0]      led_out
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Data and sync share one depth so their alignment is kept.
    logic                 sdata_meta_reg;
    logic                 sdata_reg;
    logic                 ssync_meta_reg;
    logic                 ssync_reg;
    logic [LED_COUNT-1:0] baddr_meta_reg;
    logic [LED_COUNT-1:0] baddr_reg;

    // RL1: two-wire capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sdata_meta_reg <= 1'b0;
            sdata_reg      <= 1'b0;
            ssync_meta_reg <= 1'b0;
            ssync_reg      <= 1'b0;
            baddr_meta_reg <= '0;
            baddr_reg      <= '0;
        end else begin
            sdata_meta_reg <= status_data_in;
            sdata_reg      <= sdata_meta_reg;
            ssync_meta_reg <= status_sync_in;
            ssync_reg      <= ssync_meta_reg;
            baddr_meta_reg <= board_addr_in;
            baddr_reg      <= baddr_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Frame receiver
    // ----------------------------------------------------------------
    logic [LED_COUNT-1:0] frame_word;
    logic                 frame_stb;

    frame_rx #(
        .W             (LED_COUNT)
    ) u_rx (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .data_s        (sdata_reg),
        .sync_s        (ssync_reg),
        .frame_reg     (frame_word),
        .frame_stb_reg (frame_stb)
    );

    // ----------------------------------------------------------------
    // Bus slave and registers
    // ----------------------------------------------------------------
    logic        wr_pend_reg;
    logic        wr_pend_next;
    logic [11:0] dph_addr_reg;
    logic [11:0] dph_addr_next;
    logic [1:0]  ctrl_reg;
    logic [1:0]  ctrl_next;
    logic        restart_reg;
    logic        restart_next;
    logic [15:0] frame_cnt_reg;
    logic [15:0] frame_cnt_next;
    logic [31:0] hrdata_next;
    logic        addr_ph;
    logic        intro_reg;
    logic [LED_COUNT-1:0] addr_cap_reg;

    always_comb begin
        addr_ph        = hsel && (htrans == HTRANS_NONSEQ) && hready;
        wr_pend_next   = addr_ph && hwrite;
        dph_addr_next  = addr_ph ? haddr[11:0] : dph_addr_reg;
        ctrl_next      = ctrl_reg;
        restart_next   = 1'b0;
        frame_cnt_next = frame_stb ? frame_cnt_reg + 16'h0001 : frame_cnt_reg;
        if (wr_pend_reg && (dph_addr_reg == OFS_CTRL)) begin
            ctrl_next    = hwdata[1:0];
            restart_next = hwdata[CTRL_RESTART_BIT];
        end
        hrdata_next = 32'h0000_0000;
        // Forwarded control value keeps a read right after a write coherent
        if (addr_ph && !hwrite) begin
            case (haddr[11:0])
                OFS_CTRL:   hrdata_next = {30'h0, ctrl_next};
                OFS_STATUS: hrdata_next = {frame_cnt_reg, 15'h0, intro_reg};
                OFS_FRAME:  hrdata_next = {16'h0, frame_word};
                OFS_ADDR:   hrdata_next = {16'h0, addr_cap_reg};
                default:    hrdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg   <= 1'b0;
            dph_addr_reg  <= 12'h000;
            ctrl_reg      <= CTRL_RESET;
            restart_reg   <= 1'b0;
            frame_cnt_reg <= 16'h0000;
            hrdata        <= 32'h0000_0000;
            hreadyout     <= 1'b1;
            hresp         <= HRESP_OKAY;
        end else begin
            wr_pend_reg   <= wr_pend_next;
            dph_addr_reg  <= dph_addr_next;
            ctrl_reg      <= ctrl_next;
            restart_reg   <= restart_next;
            frame_cnt_reg <= frame_cnt_next;
            hrdata        <= hrdata_next;
            hreadyout     <= 1'b1;
            hresp         <= HRESP_OKAY;
        end
    end

    // ----------------------------------------------------------------
    // Address display timer and LED drive
    // ----------------------------------------------------------------
    logic                 intro_next;
    logic [31:0]          intro_cnt_reg;
    logic [31:0]          intro_cnt_next;
    logic [LED_COUNT-1:0] addr_cap_next;
    logic [LED_COUNT-1:0] led_next;

    always_comb begin
        intro_next     = intro_reg;
        intro_cnt_next = intro_cnt_reg;
        // RL7: timed address show
        if (restart_reg) begin
            intro_next     = 1'b1;
            intro_cnt_next = 32'h0000_0000;
        end else if (intro_reg) begin
            if (intro_cnt_reg == 32'(SHOW_CYCLES - 1)) begin
                intro_next = 1'b0;
            end else begin
                intro_cnt_next = intro_cnt_reg + 32'h0000_0001;
            end
        end
        // Strap follows the pins only while shown, frozen afterwards
        addr_cap_next = intro_reg ? baddr_reg : addr_cap_reg;
        // RL6: LED source select
        if (intro_reg || ctrl_reg[CTRL_FORCE_BIT]) begin
            led_next = addr_cap_reg;
        end else if (ctrl_reg[CTRL_EN_BIT]) begin
            // RL8: frame bits drive LEDs
            led_next = frame_word;
        end else begin
            led_next = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            intro_reg     <= 1'b1;
            intro_cnt_reg <= 32'h0000_0000;
            addr_cap_reg  <= '0;
            led_out       <= '0;
        end else begin
            intro_reg     <= intro_next;
            intro_cnt_reg <= intro_cnt_next;
            addr_cap_reg  <= addr_cap_next;
            led_out       <= led_next;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [31:0] intro_len_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            intro_len_reg <= 32'h0000_0000;
        end else if (restart_reg) begin
            intro_len_reg <= 32'h0000_0000;
        end else if (intro_reg) begin
            intro_len_reg <= intro_len_reg + 32'h0000_0001;
        end
    end

    sequence s_sync_seen;
        status_sync_in;
    endsequence

    sequence s_frame_loaded;
        ##3 frame_stb;
    endsequence

    chk_sync_to_load: assert property (@(posedge hclk) disable iff (!hresetn) // RL1
        s_sync_seen |-> s_frame_loaded)
        else $error("sync pin did not load a frame three cycles later");

    chk_intro_shows: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
        intro_reg |=> led_out == $past(addr_cap_reg))
        else $error("address not shown during intro");

    chk_intro_length: assert property (@(posedge hclk) disable iff (!hresetn) // RL7
        $fell(intro_reg) |-> intro_len_reg == SHOW_CYCLES)
        else $error("address show time wrong");

    chk_normal_display: assert property (@(posedge hclk) disable iff (!hresetn) // RL8
        (!intro_reg && !ctrl_reg[CTRL_FORCE_BIT] && ctrl_reg[CTRL_EN_BIT]) |=> led_out == $past(frame_word))
        else $error("LEDs do not follow latched frame");

    chk_frame_visible: assert property (@(posedge hclk) disable iff (!hresetn) // RL6
        (frame_stb && !intro_reg && ctrl_reg == CTRL_RESET) ##1 (ctrl_reg == CTRL_RESET) |=> led_out == $past(frame_word))
        else $error("new frame not shown on LEDs");

    chk_dark_when_off: assert property (@(posedge hclk) disable iff (!hresetn)
        (!intro_reg && ctrl_reg == 2'h0) |=> led_out == '0)
        else $error("LEDs lit while disabled");

    chk_ctrl_readback: assert property (@(posedge hclk) disable iff (!hresetn)
        (addr_ph && !hwrite && haddr[11:0] == OFS_CTRL && !wr_pend_reg) |=> hrdata == {30'h0, $past(ctrl_reg)})
        else $error("control read back wrong");

    chk_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && (hresp == HRESP_OKAY))
        else $error("slave stalled or errored");

endmodule

/* File: verif/frame_sender.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Serial status sender on the board clock
// ----------------------------------------
module frame_sender (
    input  wire logic        hclk,
    input  wire logic        start,
    input  wire logic [15:0] frame,
    output logic             busy,
    output logic             data_out,
    output logic             sync_out
);
    logic [15:0] shift_reg;
    logic [4:0]  left_reg;
    initial begin
        shift_reg = 16'h0;
        left_reg = 5'h0;
        data_out = 1'b0;
        sync_out = 1'b0;
    end
    // Low already while the last bit goes out, so frames can chain
    assign busy = (left_reg > 5'h1);
    always @(posedge hclk) begin
        if (left_reg != 5'h0) begin
            data_out <= shift_reg[15];
            shift_reg <= shift_reg << 1;
            left_reg <= left_reg - 5'h1;
            // sync for one clock with the last bit
            sync_out <= (left_reg == 5'h1);
        end else if (start) begin
            data_out <= frame[15];
            shift_reg <= frame << 1;
            left_reg <= 5'hf;
            sync_out <= 1'b0;
        end else begin
            sync_out <= 1'b0;
            // No pull on the line, so idle data keeps moving
            data_out <= ~data_out;
        end
    end
endmodule

/* File: verif/led_display_tb.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module led_display_tb
    import led_display_pkg::*;
;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        start = 1'b0;
    logic        busy;
    logic        sdata;
    logic        ssync;
    logic [15:0] frame = 16'h0;
    logic [15:0] led_out;
    logic [15:0] baddr = 16'h3c5a;
    logic [15:0] n_frames = 16'h0;
    logic [31:0] rd;
    int          n_fail = 0;
    int          tests_run = 0;

    always #20 hclk = ~hclk;

    led_display #(.SHOW_CYCLES(64)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .status_data_in(sdata),
        .status_sync_in(ssync), .board_addr_in(baddr), .led_out(led_out));
    frame_sender u_src (.hclk(hclk), .start(start), .frame(frame), .busy(busy), .data_out(sdata),
        .sync_out(ssync));

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic give_up();
        n_fail++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        close_out();
    endtask

    task automatic bus_wait();
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 50) give_up();
    endtask

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    task automatic addr_phase(input logic [11:0] a, input logic w);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        bus_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
    endtask

    task automatic ahb_write(input logic [11:0] a, input logic [31:0] d);
        addr_phase(a, 1'b1);
        hwdata <= d;
        bus_wait();
    endtask

    task automatic ahb_read(input logic [11:0] a, output logic [31:0] d);
        addr_phase(a, 1'b0);
        bus_wait();
        d = hrdata;
    endtask

    task automatic send_frame(input logic [15:0] f, input logic settle);
        int i;
        start <= 1'b1;
        frame <= f;
        @(posedge hclk);
        start <= 1'b0;
        for (i = 0; i < 40; i++) begin
            @(posedge hclk);
            if (busy === 1'b0) break;
        end
        if (i == 40) give_up();
        n_frames = n_frames + 16'h1;
        if (settle) repeat (8) @(posedge hclk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic intro_show();
        int i;
        ahb_read(OFS_STATUS, rd);
        `CHK(rd[0], 1'b1)
        // Strap passes two sync stages and the capture stage first
        repeat (4) @(posedge hclk);
        ahb_read(OFS_ADDR, rd);
        `CHK(rd[15:0], baddr)
        `CHK(led_out, baddr)
        send_frame(16'h1234, 1'b1);
        `CHK(led_out, baddr)
        ahb_read(OFS_FRAME, rd);
        `CHK(rd[15:0], 16'h1234)
        for (i = 0; i < 100; i++) begin
            ahb_read(OFS_STATUS, rd);
            if (rd[0] === 1'b0) break;
        end
        if (i == 100) give_up();
    endtask

    task automatic walk_bits();
        for (int i = 0; i < LED_COUNT; i++) begin
            send_frame(16'h1 << i, 1'b1);
            `CHK(led_out, 16'h1 << i)
        end
        send_frame(16'ha5c3, 1'b1);
        `CHK(led_out, 16'ha5c3)
        ahb_read(OFS_STATUS, rd);
        `CHK(rd[31:16], n_frames)
    endtask

    task automatic chained_frames();
        send_frame(16'hf00f, 1'b0);
        send_frame(16'h0ff0, 1'b1);
        `CHK(led_out, 16'h0ff0)
        ahb_read(OFS_STATUS, rd);
        `CHK(rd[31:16], n_frames)
    endtask

    task automatic ctrl_modes();
        ahb_write(OFS_CTRL, 32'h0);
        send_frame(16'h5555, 1'b1);
        `CHK(led_out, 16'h0)
        ahb_read(OFS_FRAME, rd);
        `CHK(rd[15:0], 16'h5555)
        ahb_write(OFS_CTRL, 32'h3);
        ahb_read(OFS_ADDR, rd);
        `CHK(rd[15:0], baddr)
        `CHK(led_out, baddr)
        ahb_write(OFS_CTRL, 32'h5);
        // Restart reaches the intro flag one cycle after the write data phase
        ahb_read(OFS_CTRL, rd);
        `CHK(rd, 32'h1)
        ahb_read(OFS_STATUS, rd);
        `CHK(rd[0], 1'b1)
        ahb_write(OFS_STATUS, 32'hffffffff);
        ahb_read(12'h100, rd);
        `CHK(rd, 32'h0)
        `CHK(hresp, HRESP_OKAY)
        ahb_read(OFS_STATUS, rd);
        `CHK(rd[31:16], n_frames)
    endtask

    task automatic mid_reset();
        ahb_write(OFS_CTRL, 32'h0);
        hresetn <= 1'b0;
        @(posedge hclk);
        @(posedge hclk);
        `CHK(led_out, 16'h0)
        hresetn <= 1'b1;
        ahb_read(OFS_CTRL, rd);
        `CHK(rd, {30'h0, CTRL_RESET})
        repeat (4) @(posedge hclk);
        `CHK(led_out, baddr)
    endtask

    initial begin
        repeat (3) @(posedge hclk);
        `CHK(led_out, 16'h0)
        hresetn <= 1'b1;
        intro_show();
        walk_bits();
        chained_frames();
        ctrl_modes();
        mid_reset();
        close_out();
    end
endmodule
